// File: src/ddl_load_if.sv
// register load front end: parallel and serial assembly, transfer, ahb-lite view
//
// Contract
// - bus data captured at falling edge of write strobe, no clock qualifier.
// - transfer code may be driven during second write, or held static.
// - load seen high copies assembly register into code-selected register; the code copies once per rising load edge.
// - serial words shift in most significant bit first.
// - serial data sampled on each rising serial clock edge.
// - code 1101 with load rising moves serial word into frequency word b.
// - command register loads only from parallel assembly; code always parallel.
// - command selects bus width, sleep, amplitude enable and synchronizer use.
// - after reset: 8-bit bus, amplitude off, synchronizer on.
// - frequency select input picks which frequency word is the phase step.
// - frequency, phase and amplitude registers update at any time.
// - each write shifts assembly left 8 or 16, new data in low bits.
// - amplitude bits 9..0 scale cosine path, bits 19..10 sine path.
// - synchronizer on: controls pass four-stage pipeline; off: bypass it.
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
module ddl_load_if
  import ddl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input ddl_host_pins_t host,
  output logic [FREQ_W-1:0] phase_step,
  output logic [PHASE_W-1:0] phase_offset,
  output logic [AMP_W-1:0] amp_cos,
  output logic [AMP_W-1:0] amp_sin,
  output logic amp_enable,
  output logic sleep_mode,
  output logic xfer_pulse
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // index 0..8 for mapped words, 15 for anything else
  function automatic logic [3:0] reg_idx(input logic [31:0] a);
    logic [3:0] idx;
    idx = 4'hf;
    if (a[31:8] == 24'h0 && a[1:0] == 2'h0) begin
      unique case (a[7:0])
        OFS_CTRL: idx = 4'h0;
        OFS_STATUS: idx = 4'h1;
        OFS_FREQ_A: idx = 4'h2;
        OFS_FREQ_B: idx = 4'h3;
        OFS_PHASE: idx = 4'h4;
        OFS_IQ: idx = 4'h5;
        OFS_PAR_ASM: idx = 4'h6;
        OFS_SER_ASM: idx = 4'h7;
        OFS_XFER_CNT: idx = 4'h8;
        default: idx = 4'hf;
      endcase
    end
    return idx;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  ddl_host_pins_t pin_s1_q;
  ddl_host_pins_t pin_s2_q;
  logic wr_n_prev_q;
  logic sclk_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // idle levels, so that no false load or clock edge follows reset
      pin_s1_q <= PINS_IDLE;
      pin_s2_q <= PINS_IDLE;
      wr_n_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= host;
      pin_s2_q <= pin_s1_q;
      wr_n_prev_q <= pin_s2_q.wr_n;
      sclk_prev_q <= pin_s2_q.shift_clk;
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [1:0] ctrl_q;
  logic [CMD_W-1:0] cmd_q;
  logic [FREQ_W-1:0] par_asm_q;
  logic [FREQ_W-1:0] ser_asm_q;
  logic [FREQ_W-1:0] freq_word_a_q;
  logic [FREQ_W-1:0] freq_word_b_q;
  logic [PHASE_W-1:0] phase_q;
  logic [IQ_W-1:0] iq_amplitude_word_q;
  logic [15:0] xfer_cnt_q;
  logic reject_q;
  logic load_prev_q;

  logic port_en;
  logic bus_width_bit;
  logic sync_bypass_bit;
  assign port_en = ctrl_q[CTRL_PORT_EN_BIT];
  assign bus_width_bit = cmd_q[CMD_BUS_WIDTH_BIT];
  assign sync_bypass_bit = cmd_q[CMD_SYNC_BYPASS_BIT];

  // ---------------------------------------------------------------
  // control pipeline
  // ---------------------------------------------------------------
  ddl_ctl_t ctl;

  ddl_ctl_pipe u_ctl_pipe (
    .hclk(hclk),
    .hresetn(hresetn),
    .bypass(sync_bypass_bit),
    .ctl_in(pin_s2_q.ctl),
    .ctl_out(ctl)
  );

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  logic wr_pend_q;
  logic [3:0] wr_idx_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;

  wire logic addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
  wire logic rd_take = addr_ok && !hwrite;
  wire logic wr_take = addr_ok && hwrite;
  wire logic [3:0] a_idx = reg_idx(haddr);
  wire logic ctrl_wr = wr_pend_q && wr_idx_q == 4'h0;
  wire logic clear_req = ctrl_wr && hwdata[CTRL_CLEAR_BIT];

  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0;
    unique case (a_idx)
      4'h0: rd_word = {30'h0, ctrl_q};
      4'h1: rd_word = {27'h0, reject_q, cmd_q};
      4'h2: rd_word = freq_word_a_q;
      4'h3: rd_word = freq_word_b_q;
      4'h4: rd_word = {20'h0, phase_q};
      4'h5: rd_word = {12'h0, iq_amplitude_word_q};
      4'h6: rd_word = par_asm_q;
      4'h7: rd_word = ser_asm_q;
      4'h8: rd_word = {16'h0, xfer_cnt_q};
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 4'hf;
      hrdata_q <= 32'h0;
      hreadyout_q <= 1'b1;
      hresp_q <= HRESP_OKAY;
    end else begin
      wr_pend_q <= wr_take;
      wr_idx_q <= a_idx;
      hreadyout_q <= 1'b1;
      hresp_q <= HRESP_OKAY;
      if (rd_take) begin
        hrdata_q <= rd_word;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RST;
    end else if (ctrl_wr) begin
      // clear bit is a pulse and never stored
      ctrl_q <= {1'b0, hwdata[CTRL_PORT_EN_BIT]};
    end
  end

  // ---------------------------------------------------------------
  // parallel assembly
  // ---------------------------------------------------------------
  // falling edge of the write strobe with chip select low
  wire logic wr_fall = port_en && !pin_s2_q.wr_n && wr_n_prev_q && !pin_s2_q.cs_n;

  // shift by bus width and insert new data low
  wire logic [FREQ_W-1:0] par_asm_d = bus_width_bit ?
    {par_asm_q[15:0], pin_s2_q.data} : {par_asm_q[23:0], pin_s2_q.data[7:0]};

  // a write landing together with the clear wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      par_asm_q <= '0;
    end else if (wr_fall) begin
      par_asm_q <= par_asm_d;
    end else if (clear_req) begin
      par_asm_q <= '0;
    end
  end

  // ---------------------------------------------------------------
  // serial assembly
  // ---------------------------------------------------------------
  // rising serial clock edge
  wire logic sclk_rise = port_en && pin_s2_q.shift_clk && !sclk_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ser_asm_q <= '0;
    end else if (sclk_rise) begin
      ser_asm_q <= {ser_asm_q[FREQ_W-2:0], pin_s2_q.shift_data_in};
    end else if (clear_req) begin
      ser_asm_q <= '0;
    end
  end

  // ---------------------------------------------------------------
  // transfer decode
  // ---------------------------------------------------------------
  // one transfer per rising edge
  wire logic load_rise = port_en && ctl.load && !load_prev_q;
  // code read only at the load edge
  wire logic tc_mod = ctl.transfer_code[TC_MOD_BIT];
  wire logic tc_serial = ctl.transfer_code[TC_SERIAL_BIT];
  wire logic [1:0] tc_dest = ctl.transfer_code[1:0];
  wire logic [FREQ_W-1:0] src_word = tc_serial ? ser_asm_q : par_asm_q;
  // command only from the parallel side; serial source is refused
  wire logic cmd_load = load_rise && !tc_mod && !tc_serial;
  wire logic cmd_reject = load_rise && !tc_mod && tc_serial;
  wire logic mod_load = load_rise && tc_mod;
  // code 1101 selects serial source into word b
  wire logic ld_freq_a = mod_load && tc_dest == DEST_FREQ_A;
  wire logic ld_freq_b = mod_load && tc_dest == DEST_FREQ_B;
  wire logic ld_phase = mod_load && tc_dest == DEST_PHASE;
  wire logic ld_iq = mod_load && tc_dest == DEST_IQ;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_prev_q <= 1'b0;
    end else begin
      load_prev_q <= ctl.load;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= CMD_RST;
    end else if (cmd_load) begin
      cmd_q <= par_asm_q[CMD_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_word_a_q <= '0;
      freq_word_b_q <= '0;
      phase_q <= '0;
      iq_amplitude_word_q <= '0;
    end else begin
      if (ld_freq_a) begin
        freq_word_a_q <= src_word;
      end
      if (ld_freq_b) begin
        freq_word_b_q <= src_word;
      end
      if (ld_phase) begin
        phase_q <= src_word[PHASE_W-1:0];
      end
      if (ld_iq) begin
        iq_amplitude_word_q <= src_word[IQ_W-1:0];
      end
    end
  end

  // set wins over the clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reject_q <= 1'b0;
      xfer_cnt_q <= 16'h0;
    end else begin
      if (cmd_reject) begin
        reject_q <= 1'b1;
      end else if (clear_req) begin
        reject_q <= 1'b0;
      end
      if (cmd_load || mod_load) begin
        xfer_cnt_q <= xfer_cnt_q + 16'h1;
      end else if (clear_req) begin
        xfer_cnt_q <= 16'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // synthesis side outputs
  // ---------------------------------------------------------------
  logic [FREQ_W-1:0] phase_step_q;
  logic [PHASE_W-1:0] phase_offset_q;
  logic [AMP_W-1:0] amp_cos_q;
  logic [AMP_W-1:0] amp_sin_q;
  logic amp_enable_q;
  logic sleep_q;
  logic xfer_pulse_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_step_q <= '0;
      phase_offset_q <= '0;
      amp_cos_q <= '0;
      amp_sin_q <= '0;
      amp_enable_q <= 1'b0;
      sleep_q <= 1'b0;
      xfer_pulse_q <= 1'b0;
    end else begin
      phase_step_q <= ctl.freq_word_select ? freq_word_b_q : freq_word_a_q;
      phase_offset_q <= phase_q;
      // low field cosine, high field sine
      amp_cos_q <= iq_amplitude_word_q[AMP_W-1:0];
      amp_sin_q <= iq_amplitude_word_q[IQ_W-1:AMP_W];
      amp_enable_q <= cmd_q[CMD_AMP_EN_BIT];
      sleep_q <= cmd_q[CMD_SLEEP_BIT];
      xfer_pulse_q <= cmd_load || mod_load;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign phase_step = phase_step_q;
  assign phase_offset = phase_offset_q;
  assign amp_cos = amp_cos_q;
  assign amp_sin = amp_sin_q;
  assign amp_enable = amp_enable_q;
  assign sleep_mode = sleep_q;
  assign xfer_pulse = xfer_pulse_q;

endmodule

// File: src/ddl_pkg.sv
// shared constants and carrier types of the dds register load front end
package ddl_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned FREQ_W = 32;
  localparam int unsigned PHASE_W = 12;
  localparam int unsigned AMP_W = 10;
  localparam int unsigned IQ_W = 20;
  localparam int unsigned SYNC_STAGES = 4;

  // ---------------------------------------------------------------
  // register byte offsets on the ahb-lite slave
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FREQ_A = 8'h08;
  localparam logic [7:0] OFS_FREQ_B = 8'h0c;
  localparam logic [7:0] OFS_PHASE = 8'h10;
  localparam logic [7:0] OFS_IQ = 8'h14;
  localparam logic [7:0] OFS_PAR_ASM = 8'h18;
  localparam logic [7:0] OFS_SER_ASM = 8'h1c;
  localparam logic [7:0] OFS_XFER_CNT = 8'h20;

  // ---------------------------------------------------------------
  // control register fields and reset value
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_PORT_EN_BIT = 0;
  localparam int unsigned CTRL_CLEAR_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;

  // ---------------------------------------------------------------
  // command register fields and reset value
  // ---------------------------------------------------------------
  localparam int unsigned CMD_BUS_WIDTH_BIT = 0;
  localparam int unsigned CMD_SLEEP_BIT = 1;
  localparam int unsigned CMD_AMP_EN_BIT = 2;
  localparam int unsigned CMD_SYNC_BYPASS_BIT = 3;
  localparam int unsigned CMD_W = 4;
  localparam logic [3:0] CMD_RST = 4'h0;

  // status register fields
  localparam int unsigned STAT_REJECT_BIT = 4;

  // ---------------------------------------------------------------
  // transfer code layout
  // ---------------------------------------------------------------
  localparam int unsigned TC_MOD_BIT = 3;
  localparam int unsigned TC_SERIAL_BIT = 2;
  localparam logic [1:0] DEST_FREQ_A = 2'h0;
  localparam logic [1:0] DEST_FREQ_B = 2'h1;
  localparam logic [1:0] DEST_PHASE = 2'h2;
  localparam logic [1:0] DEST_IQ = 2'h3;

  // ---------------------------------------------------------------
  // ahb-lite encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic load;
    logic [3:0] transfer_code;
    logic freq_word_select;
  } ddl_ctl_t;

  typedef struct packed {
    logic wr_n;
    logic cs_n;
    logic [15:0] data;
    logic shift_clk;
    logic shift_data_in;
    ddl_ctl_t ctl;
  } ddl_host_pins_t;

  // idle levels of the host pins: strobes high, everything else low
  localparam ddl_host_pins_t PINS_IDLE = '{wr_n: 1'b1, cs_n: 1'b1, default: '0};

endpackage

// File: src/ddl_ctl_pipe.sv
// four-stage pipeline for the transfer control inputs with bypass
module ddl_ctl_pipe
  import ddl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic bypass,
  input ddl_ctl_t ctl_in,
  output ddl_ctl_t ctl_out
);

  ddl_ctl_t stage_q [SYNC_STAGES];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        stage_q[i] <= '0;
      end
    end else begin
      stage_q[0] <= ctl_in;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  // bypass trades metastability margin for four cycles less latency
  assign ctl_out = bypass ? ctl_in : stage_q[SYNC_STAGES-1];

endmodule

// File: sim/ddl_load_if_props.sv
// concurrent checks on the ports of the register load front end
module ddl_load_if_props
  import ddl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input ddl_host_pins_t host,
  input wire logic [FREQ_W-1:0] phase_step,
  input wire logic [PHASE_W-1:0] phase_offset,
  input wire logic [AMP_W-1:0] amp_cos,
  input wire logic [AMP_W-1:0] amp_sin,
  input wire logic amp_enable,
  input wire logic sleep_mode,
  input wire logic xfer_pulse
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // age of the last select change; covers the select's own pipeline delay
  logic [3:0] sel_age_q;
  logic [3:0] sel_age_d;
  logic sel_prev_q;
  assign sel_age_d = (host.ctl.freq_word_select != sel_prev_q) ? 4'h0 :
                     (sel_age_q == 4'hf) ? sel_age_q : sel_age_q + 4'h1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_age_q <= 4'h0;
      sel_prev_q <= 1'b0;
    end else begin
      sel_age_q <= sel_age_d;
      sel_prev_q <= host.ctl.freq_word_select;
    end
  end

  a_pulse_single: assert property (xfer_pulse |=> !xfer_pulse [*3])
    else $error("transfer pulse repeated too soon");
  a_pulse_cause: assert property (xfer_pulse |-> host.ctl.load || $past(host.ctl.load, 3))
    else $error("transfer pulse without load");
  a_step_cause: assert property ($changed(phase_step) |-> $past(xfer_pulse) || sel_age_q < 4'hc)
    else $error("phase step changed without cause");
  a_cos_update: assert property ($changed(amp_cos) |-> $past(xfer_pulse))
    else $error("cosine amplitude changed without transfer");
  a_sin_update: assert property ($changed(amp_sin) |-> $past(xfer_pulse))
    else $error("sine amplitude changed without transfer");
  a_offset_update: assert property ($changed(phase_offset) |-> $past(xfer_pulse))
    else $error("phase offset changed without transfer");
  a_mode_update: assert property ($changed({amp_enable, sleep_mode}) |-> $past(xfer_pulse))
    else $error("mode outputs changed without transfer");
  a_reset_mode: assert property (!$past(hresetn) |-> !amp_enable && !sleep_mode)
    else $error("mode outputs not cleared after reset");
  a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("bus slave not ready or not okay");

  cover property (xfer_pulse);
  cover property ($rose(amp_enable));
  cover property ($changed(phase_step) && !xfer_pulse);
endmodule

// File: sim/ddl_host_model.sv
// host side model driving the parallel, serial and transfer pins
module ddl_host_model
  import ddl_pkg::*;
(
  input wire logic hclk,
  input wire logic xfer_pulse,
  output ddl_host_pins_t host
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    host = PINS_IDLE;
  end

  // data held three clocks around the strobe fall, then released
  task automatic par_write(input logic [15:0] d);
    host.data <= d;
    host.cs_n <= 1'b0;
    repeat (3) @(posedge hclk);
    host.wr_n <= 1'b0;
    repeat (3) @(posedge hclk);
    host.wr_n <= 1'b1;
    host.cs_n <= 1'b1;
    host.data <= ~d;
    repeat (3) @(posedge hclk);
  endtask

  // msb first, 80 ns link clock, standing low between frames
  task automatic ser_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      host.shift_data_in <= w[i];
      repeat (4) @(posedge hclk);
      host.shift_clk <= 1'b1;
      repeat (4) @(posedge hclk);
      host.shift_clk <= 1'b0;
    end
    host.shift_data_in <= ~w[0];
  endtask

  task automatic set_sel(input logic s);
    host.ctl.freq_word_select <= s;
    repeat (12) @(posedge hclk);
  endtask

  // code set first and kept past the fall; load high 11 clocks
  task automatic load_xfer(input logic [3:0] tc, output int lat, output int n);
    lat = 0;
    n = 0;
    host.ctl.transfer_code <= tc;
    repeat (2) @(posedge hclk);
    host.ctl.load <= 1'b1;
    for (int i = 1; i <= 20; i++) begin
      @(posedge hclk);
      if (i == 11) host.ctl.load <= 1'b0;
      if (xfer_pulse === 1'b1) begin
        n++;
        if (lat == 0) lat = i;
      end
    end
  endtask
endmodule

// File: sim/test_ddl_load_if.sv
// self-checking bench of the register load front end
module test_ddl_load_if
  import ddl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, xfer_pulse, amp_enable, sleep_mode;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [FREQ_W-1:0] phase_step;
  logic [PHASE_W-1:0] phase_offset;
  logic [AMP_W-1:0] amp_cos, amp_sin;
  ddl_host_pins_t host;
  int error_cnt, check_count, lat_sync, lat_byp, np;

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  ddl_load_if dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .host(host),
    .phase_step(phase_step), .phase_offset(phase_offset), .amp_cos(amp_cos),
    .amp_sin(amp_sin), .amp_enable(amp_enable), .sleep_mode(sleep_mode),
    .xfer_pulse(xfer_pulse));

  ddl_host_model host_m (.hclk(hclk), .xfer_pulse(xfer_pulse), .host(host));

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // single word transfer; the wait has no bound, the watchdog ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk32(rd, exp);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #200us;
    error_cnt++;
    print_verdict();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(OFS_CTRL, 32'h1);
    rd_chk(OFS_STATUS, 32'h0);
    chk32({30'h0, amp_enable, sleep_mode}, 32'h0);
    $display("test reset done");
    // upper byte lane carries junk: byte mode must ignore it
    for (int i = 0; i < 4; i++) host_m.par_write({8'hff, 8'(8'h12 + 8'h22 * i)});
    rd_chk(OFS_PAR_ASM, 32'h12345678);
    host_m.load_xfer(4'h8, lat_sync, np);
    chk32(32'(np), 32'h1);
    rd_chk(OFS_FREQ_A, 32'h12345678);
    chk32(phase_step, 32'h12345678);
    bus(1'b1, OFS_FREQ_A, 32'h0);
    rd_chk(OFS_FREQ_A, 32'h12345678);
    rd_chk(8'h40, 32'h0);
    $display("test byte mode done");
    host_m.par_write(16'h000d);
    host_m.load_xfer(4'h0, np, np);
    rd_chk(OFS_STATUS, 32'hd);
    chk32({30'h0, amp_enable, sleep_mode}, 32'h2);
    host_m.par_write(16'h051e);
    host_m.par_write(16'hb852);
    rd_chk(OFS_PAR_ASM, 32'h051eb852);
    host_m.load_xfer(4'h9, lat_byp, np);
    chk32(32'(lat_sync - lat_byp), 32'(SYNC_STAGES));
    rd_chk(OFS_FREQ_B, 32'h051eb852);
    host_m.set_sel(1'b1);
    chk32(phase_step, 32'h051eb852);
    $display("test word mode done");
    host_m.ser_word(32'ha5c30f1e);
    rd_chk(OFS_SER_ASM, 32'ha5c30f1e);
    host_m.load_xfer(4'hd, lat_byp, np);
    chk32(phase_step, 32'ha5c30f1e);
    host_m.load_xfer(4'h4, lat_byp, np);
    chk32(32'(np), 32'h0);
    rd_chk(OFS_STATUS, 32'h1d);
    $display("test serial done");
    v = 32'h000b5801;
    host_m.par_write(v[31:16]);
    host_m.par_write(v[15:0]);
    host_m.load_xfer(4'hb, lat_byp, np);
    chk32({22'h0, amp_cos}, {22'h0, v[9:0]});
    chk32({22'h0, amp_sin}, {22'h0, v[19:10]});
    host_m.load_xfer(4'ha, lat_byp, np);
    chk32({20'h0, phase_offset}, {20'h0, v[11:0]});
    bus(1'b1, OFS_CTRL, 32'h3);
    rd_chk(OFS_PAR_ASM, 32'h0);
    rd_chk(OFS_STATUS, 32'hd);
    bus(1'b1, OFS_CTRL, 32'h0);
    host_m.par_write(16'h000f);
    rd_chk(OFS_PAR_ASM, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h1);
    host_m.par_write(16'h000f);
    host_m.load_xfer(4'h0, np, np);
    rd_chk(OFS_STATUS, 32'hf);
    chk32({30'h0, amp_enable, sleep_mode}, 32'h3);
    $display("test modulation done");
    print_verdict();
  end
endmodule

bind ddl_load_if ddl_load_if_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .host(host),
  .phase_step(phase_step), .phase_offset(phase_offset), .amp_cos(amp_cos),
  .amp_sin(amp_sin), .amp_enable(amp_enable), .sleep_mode(sleep_mode),
  .xfer_pulse(xfer_pulse));
